// ### design/lsg_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsg_regs.svh"

module lsg_timing
	import lsg_pkg::*;
(
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Panel timing
	output logic line_sync_out,
	output logic frame_sync_out,
	output logic pixel_valid
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Returns the storage slot, 10 for the status word, 15 when unmapped.
	function automatic lsg_sel_t reg_slot(input logic [15:0] a);
		lsg_sel_t s;
		s = 4'hF;
		if (a[1:0] == 2'h0) begin
			case (a[13:2])
				`LSG_IDX_LINE_TOTAL: s = 4'h0;
				`LSG_IDX_LINE_VISIBLE: s = 4'h1;
				`LSG_IDX_HDS: s = 4'h2;
				`LSG_IDX_HSW: s = 4'h3;
				`LSG_IDX_HPS: s = 4'h4;
				`LSG_IDX_VT: s = 4'h5;
				`LSG_IDX_VDL: s = 4'h6;
				`LSG_IDX_VDS: s = 4'h7;
				`LSG_IDX_VSW: s = 4'h8;
				`LSG_IDX_VPS: s = 4'h9;
				`LSG_IDX_STATUS: s = 4'hA;
				default: s = 4'hF;
			endcase
		end
		if (a[15:14] != 2'h0) begin
			s = 4'hF;
		end
		return s;
	endfunction

	function automatic lsg_word_t slot_mask(input int i);
		lsg_word_t m;
		case (i)
			1: m = `LSG_MASK_VISIBLE;
			3: m = `LSG_MASK_HSW;
			8: m = `LSG_MASK_VSW;
			default: m = `LSG_MASK_12;
		endcase
		return m;
	endfunction

	lsg_word_t cfg [0:`LSG_NUM_REGS-1];
	lsg_sel_t slot;
	logic wr_en;
	lsg_word_t status_word;
	lsg_count_t h_cnt;
	lsg_count_t v_cnt;

	assign slot = reg_slot(paddr);
	assign wr_en = psel && penable && pwrite && (slot < 4'hA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && (slot == 4'hF);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	// Byte lanes 0 and 1 carry the 16-bit registers; lanes 2 and 3 are ignored.
	genvar gi;
	generate
		for (gi = 0; gi < `LSG_NUM_REGS; gi++) begin : g_reg
			localparam lsg_word_t wr_mask = slot_mask(gi);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg[gi] <= `LSG_RESET_VAL;
				end else if (wr_en && (slot == lsg_sel_t'(gi))) begin
					if (pstrb[0]) begin
						cfg[gi][7:0] <= pwdata[7:0] & wr_mask[7:0];
					end
					if (pstrb[1]) begin
						cfg[gi][15:8] <= pwdata[15:8] & wr_mask[15:8];
					end
				end
			end
		end
	endgenerate

	// Read data is captured in the setup cycle so the access phase needs no wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			if (slot < 4'hA) begin
				prdata <= {16'h0000, cfg[slot]};
			end else if (slot == 4'hA) begin
				prdata <= {16'h0000, status_word};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Field views
	// ----------------------------------------------------------------
	lsg_count_t line_total_count;
	lsg_count_t vt;
	lsg_wide_t hde_start;
	lsg_wide_t hde_end;
	lsg_wide_t hs_start;
	lsg_wide_t hs_end;
	lsg_wide_t vde_start;
	lsg_wide_t vde_end;
	lsg_wide_t vs_start;
	lsg_wide_t vs_end;
	logic h_pol;
	logic v_pol;
	logic h_act;
	logic v_act;
	logic hs_act;
	logic vs_act;
	logic line_end;

	assign line_total_count = cfg[0][11:0];
	assign vt = cfg[5][11:0];
	assign hde_start = {2'h0, cfg[2][11:0]} + 14'h0001;
	assign hde_end = hde_start + {2'h0, cfg[1][10:0], 1'b0} + 14'h0002;
	assign hs_start = {2'h0, cfg[4][11:0]};
	assign hs_end = hs_start + {5'h00, cfg[3][`LSG_HPW_MSB:0]} + 14'h0001;
	assign vde_start = {2'h0, cfg[7][11:0]};
	assign vde_end = vde_start + {2'h0, cfg[6][11:0]} + 14'h0001;
	assign vs_start = {2'h0, cfg[9][11:0]};
	assign vs_end = vs_start + {9'h000, cfg[8][`LSG_VPW_MSB:0]} + 14'h0001;
	assign h_pol = cfg[3][`LSG_POL_BIT];
	assign v_pol = cfg[8][`LSG_POL_BIT];

	assign h_act = ({2'h0, h_cnt} >= hde_start) && ({2'h0, h_cnt} < hde_end);
	assign v_act = ({2'h0, v_cnt} >= vde_start) && ({2'h0, v_cnt} < vde_end);
	assign hs_act = ({2'h0, h_cnt} >= hs_start) && ({2'h0, h_cnt} < hs_end);
	assign vs_act = ({2'h0, v_cnt} >= vs_start) && ({2'h0, v_cnt} < vs_end);
	assign line_end = (h_cnt >= line_total_count);

	// ----------------------------------------------------------------
	// Pixel and line counters
	// ----------------------------------------------------------------
	// Compare with >= so that lowering a total mid-line cannot strand a counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h_cnt <= 12'h000;
		end else if (line_end) begin
			h_cnt <= 12'h000;
		end else begin
			h_cnt <= h_cnt + 12'h001;
		end
	end

	// A zero vertical total gives a one-line frame; software avoids it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v_cnt <= 12'h000;
		end else if (line_end) begin
			if (v_cnt >= vt) begin
				v_cnt <= 12'h000;
			end else begin
				v_cnt <= v_cnt + 12'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sync and valid outputs
	// ----------------------------------------------------------------
	// Reset levels are the idle levels of the default active-low polarity.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_sync_out <= 1'b1;
		end else begin
			line_sync_out <= hs_act ? h_pol : ~h_pol;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_sync_out <= 1'b1;
		end else begin
			frame_sync_out <= vs_act ? v_pol : ~v_pol;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pixel_valid <= 1'b0;
		end else begin
			pixel_valid <= h_act && v_act;
		end
	end

	assign status_word = {pixel_valid, ~v_act, 2'h0, v_cnt};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic cfg_quiet;
	assign cfg_quiet = !wr_en;

	a_line_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(h_cnt == line_total_count) |=> (h_cnt == 12'h000))
		else $error("pixel counter did not wrap at total");

	a_pixel_step: assert property (@(posedge pclk) disable iff (!presetn)
		(h_cnt < line_total_count) && cfg_quiet |=> (h_cnt == $past(h_cnt) + 12'h001))
		else $error("pixel counter did not advance by one");

	a_frame_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(h_cnt == line_total_count) && (v_cnt == vt) |=> (v_cnt == 12'h000))
		else $error("line counter did not wrap at vertical total");

	a_line_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(h_cnt < line_total_count) |=> $stable(v_cnt))
		else $error("line counter moved inside a line");

	a_hsync_start: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, h_cnt} == hs_start) && cfg_quiet |=> (line_sync_out == $past(h_pol)))
		else $error("line sync not active at its start position");

	a_hsync_end: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, h_cnt} == hs_end) && cfg_quiet |=> (line_sync_out == !$past(h_pol)))
		else $error("line sync still active past its width");

	a_vsync_start: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, v_cnt} == vs_start) && cfg_quiet |=> (frame_sync_out == $past(v_pol)))
		else $error("frame sync not active on its start line");

	a_valid_first: assert property (@(posedge pclk) disable iff (!presetn)
		pixel_valid |-> ({2'h0, $past(h_cnt)} >= $past(hde_start)) && $past(v_act))
		else $error("pixel valid outside display window");

	a_valid_vert: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, v_cnt} == vde_end) && cfg_quiet |=> !pixel_valid)
		else $error("pixel valid after the last display line");

	a_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && (slot == 4'hF) |-> pslverr && pready)
		else $error("unmapped access not flagged");

	a_hsync_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!hs_act |=> (line_sync_out == !$past(h_pol)))
		else $error("line sync not at its idle level");

	a_fsync_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!vs_act |=> (frame_sync_out == !$past(v_pol)))
		else $error("frame sync not at its idle level");

	a_vsync_end: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, v_cnt} == vs_end) |=> (frame_sync_out == !$past(v_pol)))
		else $error("frame sync still active past its width");

	a_valid_start: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, h_cnt} == hde_start) && v_act |=> pixel_valid)
		else $error("pixel valid missing at first display pixel");

	a_valid_end: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, h_cnt} == hde_end) |=> !pixel_valid)
		else $error("pixel valid past the display width");

	a_vdisp_start: assert property (@(posedge pclk) disable iff (!presetn)
		({2'h0, v_cnt} == vde_start) && h_act |=> pixel_valid)
		else $error("pixel valid missing on first display line");

endmodule // lsg_timing

`default_nettype wire

// ### design/lsg_regs.svh
`ifndef LSG_REGS_SVH
`define LSG_REGS_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------
`define LSG_IDX_LINE_TOTAL 12'h802
`define LSG_IDX_LINE_VISIBLE 12'h804
`define LSG_IDX_HDS 12'h806
`define LSG_IDX_HSW 12'h808
`define LSG_IDX_HPS 12'h80A
`define LSG_IDX_VT 12'h80C
`define LSG_IDX_VDL 12'h80E
`define LSG_IDX_VDS 12'h810
`define LSG_IDX_VSW 12'h812
`define LSG_IDX_VPS 12'h814
`define LSG_IDX_STATUS 12'h81E

// ----------------------------------------------------------------
// Writable bit masks and reset value
// ----------------------------------------------------------------
`define LSG_MASK_12 16'h0FFF
`define LSG_MASK_VISIBLE 16'h07FF
`define LSG_MASK_HSW 16'h81FF
`define LSG_MASK_VSW 16'h801F
`define LSG_RESET_VAL 16'h0000

// ----------------------------------------------------------------
// Field positions and register count
// ----------------------------------------------------------------
`define LSG_POL_BIT 15
`define LSG_HPW_MSB 8
`define LSG_VPW_MSB 4
`define LSG_ST_VALID_BIT 15
`define LSG_ST_VBLANK_BIT 14
`define LSG_NUM_REGS 10

`endif

// ### design/lsg_pkg.sv
package lsg_pkg;
	typedef logic [11:0] lsg_count_t;
	typedef logic [13:0] lsg_wide_t;
	typedef logic [15:0] lsg_word_t;
	typedef logic [3:0] lsg_sel_t;
endpackage

// ### verif/lsg_panel_model.sv
`timescale 1ns/1ps
`default_nettype none

// The panel only samples the timing lines, so it tallies the pixels it was handed.
module lsg_panel_model (
	// Clock
	input wire logic pclk,
	// Timing from the generator
	input wire logic pixel_valid,
	// Tally of accepted pixels
	output int px_count
);
	initial px_count = 0;
	always @(posedge pclk) begin
		if (pixel_valid === 1'b1) px_count <= px_count + 1;
	end
endmodule // lsg_panel_model

`default_nettype wire

// ### verif/lcd_sync_timing_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsg_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module lcd_sync_timing_generator_tb;
	import lsg_pkg::*;
	localparam logic [11:0] RIDX [10] = '{`LSG_IDX_LINE_TOTAL, `LSG_IDX_LINE_VISIBLE, `LSG_IDX_HDS,
		`LSG_IDX_HSW, `LSG_IDX_HPS, `LSG_IDX_VT, `LSG_IDX_VDL, `LSG_IDX_VDS, `LSG_IDX_VSW, `LSG_IDX_VPS};
	localparam logic [15:0] RMASK [10] = '{16'h0FFF, 16'h07FF, 16'h0FFF, 16'h81FF, 16'h0FFF,
		16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h801F, 16'h0FFF};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready, pslverr, line_sync_out, frame_sync_out, pixel_valid;
	logic e_ls = 1'b1, e_fs = 1'b1, e_pv = 1'b0;
	logic [31:0] seed = 32'd94;
	logic [15:0] st_exp = 16'h0000;
	wire logic [15:0] lane = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	int miscompares = 0, n_compared = 0, cyc = 0, h = 0, v = 0, px = 0, px_count;
	int sh[10];
	int cfg[10];

	always #50 pclk = ~pclk;

	lsg_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out), .pixel_valid(pixel_valid));
	lsg_panel_model panel (.pclk(pclk), .pixel_valid(pixel_valid), .px_count(px_count));

	function automatic int slot(input logic [15:0] a);
		slot = -1;
		for (int i = 0; i < 10; i++) if (a === {2'b00, RIDX[i], 2'b00}) slot = i;
	endfunction

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// ----------------------------------------------------------------
	// Reference model: outputs lag the counters by one edge.
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h = 0; v = 0; e_ls = 1'b1; e_fs = 1'b1; e_pv = 1'b0;
			foreach (sh[i]) sh[i] = 0;
		end else begin
			if (psel && !penable && paddr === {2'b00, `LSG_IDX_STATUS, 2'b00})
				st_exp = {e_pv, !(v >= sh[7] && v <= sh[7] + sh[6]), 2'b00, 12'(v)};
			e_ls = (h >= sh[4] && h <= sh[4] + (sh[3] & 'h1FF)) == (sh[3] >> 15);
			e_fs = (v >= sh[9] && v <= sh[9] + (sh[8] & 'h1F)) == (sh[8] >> 15);
			e_pv = h > sh[2] && h <= sh[2] + 2 * (sh[1] + 1) && v >= sh[7] && v <= sh[7] + sh[6];
			if (h >= sh[0]) begin
				h = 0;
				v = (v >= sh[5]) ? 0 : v + 1;
			end else h++;
			if (psel && penable && pwrite && pready && slot(paddr) >= 0)
				sh[slot(paddr)] = (sh[slot(paddr)] & ~32'(lane)) | (pwdata[15:0] & RMASK[slot(paddr)] & lane);
		end
	end

	always @(negedge pclk) begin
		`CHK("line_sync_out", e_ls, line_sync_out)
		`CHK("frame_sync_out", e_fs, frame_sync_out)
		`CHK("pixel_valid", e_pv, pixel_valid)
		`CHK("panel pixels", px, px_count)
		px += e_pv;
		cyc++;
		if (cyc > 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		logic [31:0] rd;
		logic err;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, {2'b00, RIDX[i], 2'b00}, 16'h0000, rd, err);
			`CHK("reset value", 32'h00000000, rd)
		end
		// Each pass flips the line sync polarity, every second pass the frame sync polarity, and keeps the setup legal for software.
		for (int k = 0; k < 6; k++) begin
			cfg[0] = 20 + rnd() % 20;
			cfg[5] = 2 + rnd() % 6;
			cfg[1] = rnd() % 4; cfg[2] = rnd() % 6; cfg[4] = rnd() % cfg[0];
			cfg[3] = ((k % 2) << 15) | (rnd() % 4);
			cfg[6] = rnd() % cfg[5];
			cfg[7] = rnd() % 3; cfg[9] = rnd() % cfg[5];
			cfg[8] = (((k / 2) % 2) << 15) | (rnd() % 3);
			for (int i = 0; i < 10; i++) begin
				apb(1'b1, {2'b00, RIDX[i], 2'b00}, 16'(cfg[i] | (rnd() & ~RMASK[i])), rd, err);
				apb(1'b0, {2'b00, RIDX[i], 2'b00}, 16'h0000, rd, err);
				`CHK("readback", 32'(cfg[i]), rd)
			end
			repeat (2 * (cfg[0] + 1) * (cfg[5] + 1)) @(posedge pclk);
		end
		// Only the upper byte lane is written; the lower byte keeps its old value.
		pstrb <= 4'h2;
		apb(1'b1, {2'b00, RIDX[4], 2'b00}, 16'hABCD, rd, err);
		pstrb <= 4'hF;
		apb(1'b0, {2'b00, RIDX[4], 2'b00}, 16'h0000, rd, err);
		`CHK("strobe write", 32'((cfg[4] & 'hFF) | 'h0B00), rd)
		`CHK("mapped error", 1'b0, err)
		apb(1'b0, {2'b00, `LSG_IDX_STATUS, 2'b00}, 16'h0000, rd, err);
		`CHK("status", {16'h0000, st_exp}, rd)
		apb(1'b1, {2'b00, `LSG_IDX_STATUS, 2'b00}, 16'hFFFF, rd, err);
		`CHK("status write error", 1'b0, err)
		// A second reset in mid-frame must bring every register and output back to idle.
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, {2'b00, RIDX[i], 2'b00}, 16'h0000, rd, err);
			`CHK("second reset", 32'h00000000, rd)
		end
		repeat (20) @(posedge pclk);
		apb(1'b1, 16'h2004, 16'hFFFF, rd, err);
		`CHK("pslverr write", 1'b1, err)
		apb(1'b0, 16'h2009, 16'h0000, rd, err);
		`CHK("pslverr read", 1'b1, err)
		`CHK("unmapped data", 32'h00000000, rd)
		tally_and_finish();
	end
endmodule // lcd_sync_timing_generator_tb

`default_nettype wire
